// File: src/ars_pkg.sv
// shared types and constants of the converter reset and sync sequencer
// assumes one core clock; the sampling clock arrives as a one-cycle tick
package ars_pkg;

  // ==========================================================
  // sample and frame layout
  localparam int ARS_CODE_W = 10;   // converter code width
  localparam int ARS_PORTS = 4;     // demultiplexer ports a..d
  localparam int ARS_SLOT_W = 2;    // slot pointer width

  typedef struct packed {
    logic oor;                      // out-of-range flag
    logic [ARS_CODE_W-1:0] code;    // converted code
  } ars_sample_t;

  typedef struct packed {
    ars_sample_t port_d;            // fourth sample
    ars_sample_t port_c;            // third sample
    ars_sample_t port_b;            // second sample
    ars_sample_t port_a;            // first sample
  } ars_frame_t;

  // ==========================================================
  // configuration register file
  localparam int ARS_CFG_AW = 3;    // eight configuration words
  localparam int ARS_CFG_DW = 16;   // word width
  localparam logic [ARS_CFG_AW-1:0] ARS_CFG_ADDR_POL = 3'h6;  // holds polarity bit
  localparam int ARS_POL_BIT = 8;   // sync reset polarity bit position
  localparam logic [ARS_CFG_DW-1:0] ARS_CFG_DEF = 16'h0000;     // default, plain words
  localparam logic [ARS_CFG_DW-1:0] ARS_CFG_DEF_POL = 16'h0100; // default, active high

  // ==========================================================
  // slot and pattern constants
  localparam logic [ARS_SLOT_W-1:0] ARS_SLOT_FIRST = 2'h0;  // port a slot
  localparam logic [ARS_SLOT_W-1:0] ARS_SLOT_LAST = 2'h3;   // port d slot
  localparam logic [ARS_SLOT_W-1:0] ARS_SLOT_HIGH = 2'h2;   // ready clock high from here
  localparam logic [ARS_CODE_W-1:0] ARS_CHK_EVEN = 10'h155; // checkerboard phase 0
  localparam logic [ARS_CODE_W-1:0] ARS_CHK_ODD = 10'h2AA;  // checkerboard phase 1

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ARS_ST_SYNC = 2'b00,            // output clock sync reset held
    ARS_ST_WAIT = 2'b01,            // released, waiting for first sampling edge
    ARS_ST_RUN = 2'b10              // converting
  } ars_state_t;

endpackage

// File: src/ars_sequencer.sv
// converter reset, output clock sync and demultiplexer order logic
// assumes all pins synchronous to core_clk; sampling edges come as sample_tick
//
// Notes on behaviour
// - sync reset realigns the ready clock generator
// - first ready clock transition is a rise
// - first sample lands in slot a
// - order reset realigns ports a, b, c, d
// - order reset restarts the checkerboard pattern
// - config reset restores all config defaults
// - sync reset polarity from config bit
// - order reset is active high
// - basic sequence gives no fixed latency
// - all converters start on first restarted edge
`timescale 1ns/1ps
`default_nettype none

module ars_sequencer (
  input wire logic core_clk,                               // core clock, 40 MHz
  input wire logic sys_rst,                                // async reset, active high
  input wire logic output_clock_sync_reset,                // sync reset pin, polarity set
  input wire logic demux_order_reset,                      // order reset, active high
  input wire logic config_reset,                           // config defaults, active high
  input wire logic cfg_wr_en,                              // config write strobe
  input wire logic [ars_pkg::ARS_CFG_AW-1:0] cfg_addr,     // config word address
  input wire logic [ars_pkg::ARS_CFG_DW-1:0] cfg_wr_data,  // config write data
  output logic [ars_pkg::ARS_CFG_DW-1:0] cfg_rd_data,      // addressed config word
  input wire logic sample_tick,                            // sampling clock rising edge
  input wire ars_pkg::ars_sample_t sample_in,              // converted sample
  input wire logic test_pattern_en,                        // checkerboard instead of data
  output logic sample_ready_clock,                         // output data clock level
  output ars_pkg::ars_frame_t frame_out,                   // demultiplexed ports a..d
  output logic frame_valid,                                // one-cycle pulse per frame
  output logic sync_active,                                // sync reset seen as active
  output logic running                                     // converter running
);
  import ars_pkg::*;

  // ==========================================================
  // configuration register file
  logic [ARS_CFG_DW-1:0] cfg_reg [2**ARS_CFG_AW];  // config words
  logic [ARS_CFG_DW-1:0] cfg_next [2**ARS_CFG_AW]; // next config words
  logic [ARS_CFG_DW-1:0] rd_reg;                   // registered read data
  logic [ARS_CFG_DW-1:0] rd_next;                  // next read data

  // default of one word
  function automatic logic [ARS_CFG_DW-1:0] cfg_default(input int idx);
    logic [ARS_CFG_DW-1:0] val;
    val = (idx == int'(ARS_CFG_ADDR_POL)) ? ARS_CFG_DEF_POL : ARS_CFG_DEF;
    return val;
  endfunction

  // next values: config reset wins over a write
  always_comb begin
    for (int i = 0; i < 2**ARS_CFG_AW; i++) begin
      if (config_reset) begin
        cfg_next[i] = cfg_default(i);
      end else if (cfg_wr_en && (cfg_addr == i[ARS_CFG_AW-1:0])) begin
        cfg_next[i] = cfg_wr_data;    // plain write
      end else begin
        cfg_next[i] = cfg_reg[i];     // hold
      end
    end
    rd_next = cfg_reg[cfg_addr];
  end

  // register the config file
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 2**ARS_CFG_AW; i++) begin
        cfg_reg[i] <= (i == int'(ARS_CFG_ADDR_POL)) ? ARS_CFG_DEF_POL : ARS_CFG_DEF;
      end
      rd_reg <= ARS_CFG_DEF;
    end else begin
      for (int i = 0; i < 2**ARS_CFG_AW; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
      rd_reg <= rd_next;
    end
  end

  assign cfg_rd_data = rd_reg;

  // ==========================================================
  // reset decode
  logic sync_pol;    // 1: sync reset active high
  logic sync_now;    // sync reset active this cycle
  logic order_now;   // order reset active this cycle

  always_comb begin
    sync_pol = cfg_reg[ARS_CFG_ADDR_POL][ARS_POL_BIT];
    sync_now = sync_pol ? output_clock_sync_reset : ~output_clock_sync_reset;
    order_now = demux_order_reset;
  end

  // ==========================================================
  // sequencer, slot pointer, ready clock and pattern state
  ars_state_t state_reg;                 // sequencer state
  ars_state_t state_next;                // next state
  logic [ARS_SLOT_W-1:0] slot_reg;       // slot of next sample
  logic [ARS_SLOT_W-1:0] slot_next;      // next slot
  logic ready_reg;                       // ready clock level
  logic ready_next;                      // next ready clock level
  logic chk_reg;                         // checkerboard phase
  logic chk_next;                        // next checkerboard phase
  ars_frame_t acc_reg;                   // samples gathered so far
  ars_frame_t acc_next;                  // next gathered samples
  ars_frame_t frame_reg;                 // output frame
  ars_frame_t frame_next;                // next output frame
  logic valid_reg;                       // frame pulse
  logic valid_next;                      // next frame pulse
  ars_sample_t smp;                      // sample or pattern to store
  logic take;                            // store a sample this cycle

  always_comb begin
    state_next = state_reg;
    slot_next = slot_reg;
    ready_next = ready_reg;
    chk_next = chk_reg;
    acc_next = acc_reg;
    frame_next = frame_reg;
    valid_next = 1'b0;
    take = 1'b0;
    // pattern or live sample
    smp.oor = test_pattern_en ? 1'b0 : sample_in.oor;
    smp.code = test_pattern_en ? (chk_reg ? ARS_CHK_ODD : ARS_CHK_EVEN) : sample_in.code;
    unique case (state_reg)
      ARS_ST_SYNC: begin
        // generator held and realigned, ready clock parked low
        ready_next = 1'b0;
        slot_next = ARS_SLOT_FIRST;
        if (!sync_now) begin
          state_next = ARS_ST_WAIT;
        end
      end
      ARS_ST_WAIT: begin
        // no edge counted until the sampling clock restarts
        if (sync_now) begin
          state_next = ARS_ST_SYNC;
        end else if (sample_tick) begin
          state_next = ARS_ST_RUN;
          take = 1'b1;
        end
      end
      ARS_ST_RUN: begin
        // free running; latency only fixed if the clock was stopped during resets
        if (sync_now) begin
          state_next = ARS_ST_SYNC;
          ready_next = 1'b0;
          slot_next = ARS_SLOT_FIRST;
        end else if (sample_tick) begin
          take = 1'b1;
        end
      end
      default: begin
        state_next = ARS_ST_SYNC;    // illegal code recovers into reset
        ready_next = 1'b0;
        slot_next = ARS_SLOT_FIRST;
      end
    endcase
    // store one sample into its slot
    if (take) begin
      unique case (slot_reg)
        2'h0: acc_next.port_a = smp;
        2'h1: acc_next.port_b = smp;
        2'h2: acc_next.port_c = smp;
        default: acc_next.port_d = smp;
      endcase
      slot_next = slot_reg + 2'h1;
      chk_next = ~chk_reg;
      // low for two samples, high for two: the first change is a rise
      ready_next = (slot_next >= ARS_SLOT_HIGH);
      if (slot_reg == ARS_SLOT_LAST) begin
        frame_next = acc_next;
        frame_next.port_d = smp;
        valid_next = 1'b1;
      end
    end
    // order reset realigns slots and pattern, whatever the state
    if (order_now) begin
      slot_next = ARS_SLOT_FIRST;
      chk_next = 1'b0;
      acc_next = '0;
      valid_next = 1'b0;
    end
  end

  // register sequencer state
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ARS_ST_SYNC;
      slot_reg <= ARS_SLOT_FIRST;
      ready_reg <= 1'b0;
      chk_reg <= 1'b0;
      acc_reg <= '0;
      frame_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      slot_reg <= slot_next;
      ready_reg <= ready_next;
      chk_reg <= chk_next;
      acc_reg <= acc_next;
      frame_reg <= frame_next;
      valid_reg <= valid_next;
    end
  end

  // ==========================================================
  // outputs
  assign sample_ready_clock = ready_reg;
  assign frame_out = frame_reg;
  assign frame_valid = valid_reg;
  assign sync_active = sync_now;
  assign running = (state_reg == ARS_ST_RUN);

endmodule

`default_nettype wire

// File: testbench/ars_seq_chk.sv
// port checker for the converter reset and sync sequencer
// assumes it is bound to ars_sequencer with all pins connected by name
`timescale 1ns/1ps
`default_nettype none
module ars_seq_chk
  import ars_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic sys_rst, // async reset, active high
  input wire logic demux_order_reset, // order reset pin
  input wire logic config_reset, // config defaults pin
  input wire logic [ARS_CFG_AW-1:0] cfg_addr, // config address
  input wire logic [ARS_CFG_DW-1:0] cfg_rd_data, // config read word
  input wire logic sample_tick, // sampling edge
  input wire logic sample_ready_clock, // output data clock
  input wire ars_frame_t frame_out, // ports a..d
  input wire logic frame_valid, // frame pulse
  input wire logic sync_active, // decoded sync reset
  input wire logic running // converter running
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // assertions
  chk_sync_holds_all: assert property (sync_active |=> !running && !sample_ready_clock && !frame_valid)
    else $error("sync reset did not hold the converter");
  chk_first_edge_rise: assert property ($fell(sample_ready_clock) |-> $past(running))
    else $error("ready clock fell before a rise");
  chk_start_on_tick: assert property ($rose(running) |-> $past(sample_tick) && !$past(sync_active))
    else $error("converter started without a sampling edge");
  chk_order_no_valid: assert property (demux_order_reset |=> !frame_valid)
    else $error("frame emitted during order reset");
  chk_valid_one_cycle: assert property (frame_valid |=> !frame_valid)
    else $error("frame pulse longer than one cycle");
  chk_frame_on_valid: assert property ($changed(frame_out) |-> frame_valid)
    else $error("frame changed without its pulse");
  chk_frame_ready_low: assert property (frame_valid |-> !sample_ready_clock)
    else $error("ready clock high at frame end");
  chk_cfg_defaults: assert property (config_reset |=> ##1
    cfg_rd_data == (($past(cfg_addr) == ARS_CFG_ADDR_POL) ? ARS_CFG_DEF_POL : ARS_CFG_DEF))
    else $error("config word not back at default");
  // the first stored sample leaves the ready clock low, so its first change is a rise
  chk_first_sample_low: assert property ($rose(running) |-> !sample_ready_clock)
    else $error("ready clock high after the first sample");
  // main scenarios reached
  cover property (frame_valid);
  cover property ($rose(running));
  cover property (config_reset ##1 !config_reset);
endmodule
`default_nettype wire

// File: testbench/ars_ctrl_model.sv
// controller model: sequences the three resets and gates the sampling clock
// assumes the bench asks for sequences and sampling edges on core_clk
`timescale 1ns/1ps
`default_nettype none
module ars_ctrl_model (
  input wire logic core_clk, // core clock
  input wire logic start, // begin a reset sequence
  input wire logic pol_high, // sync reset active level
  input wire logic tick_req, // bench wants a sampling edge
  output logic sync_pin, // sync reset pin
  output logic order_rst, // order reset pin
  output logic cfg_rst, // config reset pin
  output logic tick, // gated sampling edge
  output logic busy // sequence in progress
);
  logic [2:0] cnt_reg = 3'h0; // phase counter, 0 idle
  // each phase lasts one 25 ns cycle, above the minimum widths
  always @(posedge core_clk) begin
    if (cnt_reg != 3'h0) begin
      cnt_reg <= (cnt_reg == 3'h5) ? 3'h0 : cnt_reg + 3'h1;
    end else if (start) begin
      cnt_reg <= 3'h1;
    end
  end
  assign busy = cnt_reg != 3'h0;
  // sync held over phases 1..4, order reset nested inside
  assign sync_pin = (cnt_reg >= 3'h1 && cnt_reg <= 3'h4) ? pol_high : !pol_high;
  assign order_rst = cnt_reg == 3'h2 || cnt_reg == 3'h3;
  assign cfg_rst = cnt_reg == 3'h2;
  // sampling clock stopped low until the sequence ends, one phase after sync is released
  assign tick = tick_req && !busy;
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the reset and sync sequencer
// assumes ars_pkg, ars_sequencer, ars_ctrl_model and ars_seq_chk compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ars_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, start = 1'b0, pol_high = 1'b1, tick_req = 1'b0;
  logic sync_pin, order_rst, cfg_rst, tick, busy, sample_ready_clock, frame_valid;
  logic sync_active, running, cfg_wr_en = 1'b0, test_pattern_en = 1'b0;
  logic [2:0] cfg_addr = 3'h0;
  logic [15:0] cfg_wr_data = 16'h0000, cfg_rd_data;
  ars_sample_t sample_in = '0;
  ars_frame_t frame_out;
  int num_errors = 0, tests_run = 0;
  int unsigned seed;
  ars_sequencer ars_sequencer_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .output_clock_sync_reset(sync_pin), .demux_order_reset(order_rst), .config_reset(cfg_rst),
    .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data),
    .cfg_rd_data(cfg_rd_data), .sample_tick(tick), .sample_in(sample_in),
    .test_pattern_en(test_pattern_en), .sample_ready_clock(sample_ready_clock),
    .frame_out(frame_out), .frame_valid(frame_valid), .sync_active(sync_active),
    .running(running));
  ars_ctrl_model ars_ctrl_model_inst (.core_clk(core_clk), .start(start), .pol_high(pol_high),
    .tick_req(tick_req), .sync_pin(sync_pin), .order_rst(order_rst), .cfg_rst(cfg_rst),
    .tick(tick), .busy(busy));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  function automatic logic [15:0] cfg_def(input logic [2:0] a);
    return (a == ARS_CFG_ADDR_POL) ? ARS_CFG_DEF_POL : ARS_CFG_DEF;
  endfunction
  task automatic cfg_rd(input logic [2:0] a, input logic [15:0] exp);
    cfg_addr = a;
    step();
    check(cfg_rd_data, exp);
  endtask
  task automatic defaults();
    for (int a = 0; a < 8; a++) cfg_rd(a[2:0], cfg_def(a[2:0]));
  endtask
  task automatic cfg_wr(input logic [2:0] a, input logic [15:0] d);
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wr_data = d;
    step();
    cfg_wr_en = 1'b0;
    step();
  endtask
  task automatic run_seq();
    start = 1'b1;
    step();
    start = 1'b0;
    repeat (2) step();
    check(sync_active, 1'b1);
    repeat (5) step();
    check(running, 1'b0);
  endtask
  // four back-to-back sampling edges, one frame expected; caller lowers tick_req
  task automatic frame(input bit pat);
    ars_sample_t s[4];
    tick_req = 1'b1;
    for (int i = 0; i < 4; i++) begin
      s[i] = pat ? {1'b0, i[0] ? ARS_CHK_ODD : ARS_CHK_EVEN} : ars_sample_t'(11'($urandom));
      sample_in = s[i];
      step();
      // ready clock low after slot a, high after b and c, low again after d
      check(sample_ready_clock, (i == 1 || i == 2));
    end
    check(frame_valid, 1'b1);
    check(frame_out, {s[3], s[2], s[1], s[0]});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    seed = $urandom(32'haf616db7);
    repeat (12) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    defaults();
    run_seq();
    repeat (3) frame(1'b0);
    tick_req = 1'b0;
    for (int a = 0; a < 8; a++) cfg_wr(a[2:0], 16'($urandom));
    cfg_wr(ARS_CFG_ADDR_POL, 16'h0000);
    pol_high = 1'b0;
    cfg_rd(ARS_CFG_ADDR_POL, 16'h0000);
    check(sync_active, 1'b0);
    // back to active high before the sequence, other bits left random for the reset
    cfg_wr(ARS_CFG_ADDR_POL, 16'($urandom) | ARS_CFG_DEF_POL);
    pol_high = 1'b1;
    run_seq();
    defaults();
    tick_req = 1'b1;
    repeat (2) step();
    tick_req = 1'b0;
    run_seq();
    frame(1'b0);
    tick_req = 1'b0;
    test_pattern_en = 1'b1;
    run_seq();
    repeat (2) frame(1'b1);
    tick_req = 1'b0;
    sys_rst = 1'b1;
    step();
    sys_rst = 1'b0;
    check(running, 1'b0);
    check(frame_out, 64'h0);
    check(sample_ready_clock, 1'b0);
    end_sim();
  end
  initial begin
    #(25 * 3000);
    num_errors++;
    end_sim();
  end
endmodule
bind ars_sequencer ars_seq_chk ars_seq_chk_inst (.core_clk(core_clk), .sys_rst(sys_rst),
  .demux_order_reset(demux_order_reset), .config_reset(config_reset), .cfg_addr(cfg_addr),
  .cfg_rd_data(cfg_rd_data), .sample_tick(sample_tick), .sample_ready_clock(sample_ready_clock),
  .frame_out(frame_out), .frame_valid(frame_valid), .sync_active(sync_active),
  .running(running));
`default_nettype wire
